// file: common/ibei_consts.vh
// Purpose: shared constants for the i2c bus-error and init block
// Assumes: sys_clk at 250 MHz
// Notes: definitions only
`ifndef IBEI_CONSTS_VH
`define IBEI_CONSTS_VH
`define IBEI_CLK_MHZ 250
`define IBEI_INIT_TIME_US 550
`define IBEI_INIT_CYCLES (`IBEI_INIT_TIME_US * `IBEI_CLK_MHZ)
`define IBEI_RST_PULSE_NS 8
`define IBEI_RST_CYCLES ((`IBEI_RST_PULSE_NS * `IBEI_CLK_MHZ + 999) / 1000)
`define IBEI_STA_BUS_ERR 8'h00
`define IBEI_STA_IDLE 8'hf8
`define IBEI_CON_OSC_BIT 5
`define IBEI_CON_SI_BIT 3
`define IBEI_CON_RESET 8'h00
`define IBEI_SW_KEY0 8'ha5
`define IBEI_SW_KEY1 8'h5a
`endif

// file: rtl/ibei_sync.v
// Purpose: two-flop synchroniser for external levels
// Assumes: one sys_clk domain
// Notes: first stage read only by second stage
module ibei_sync #(
  parameter W = 2
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_r;
  // two flops, reset to bus idle (high)
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      meta_r <= {W{1'b1}};
      sync_out <= {W{1'b1}};
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// file: rtl/ibei_cond.v
// Purpose: detect START, STOP and SCL rising edges on synced lines
// Assumes: inputs already synchronised
// Notes: one-cycle pulses
module ibei_cond (
  input wire sys_clk,
  input wire rst_b,
  input wire clk_en,
  input wire scl_s,
  input wire sda_s,
  output wire start_p,
  output wire stop_p,
  output wire scl_rise_p,
  output wire bus_idle
);
  reg scl_d_r;
  reg sda_d_r;
  reg busy_r;
  // delayed copies for edge finding
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      busy_r <= 1'b0;
    end else if (clk_en) begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      if (start_p)
        busy_r <= 1'b1;
      else if (stop_p)
        busy_r <= 1'b0;
    end
  end
  assign start_p = clk_en & scl_s & scl_d_r & sda_d_r & ~sda_s; // [RULE12]
  assign stop_p = clk_en & scl_s & scl_d_r & ~sda_d_r & sda_s; // [RULE13]
  assign scl_rise_p = clk_en & scl_s & ~scl_d_r; // [RULE10]
  assign bus_idle = ~busy_r & scl_s & sda_s; // [RULE11]
endmodule

// file: rtl/ibei_top.v
// Purpose: bus-error detection, power-up init and reset for an i2c controller
// Assumes: host drives reset pin, sw reset strobes and transfer role flags
// Notes: frame bit counting follows scl rising edges on the synced lines
// What this block does
// [RULE1] start or stop inside a byte or acknowledge is a bus error; code does not flag one during the ack clock high (count 0)
// [RULE2] bus errors matter only while master or addressed slave
// [RULE3] on bus error release lines, set interrupt flag, status becomes 00h
// [RULE4] host must reset the device after a bus error
// [RULE5] after power-on reset: oscillator bit high, init registers, then low, idle
// [RULE6] power-up initialization finishes within 550 microseconds
// [RULE7] host does not write during init; reads are answered
// [RULE8] oscillator bit reads 1 during init and 0 when ready
// [RULE9] reset pin held low long enough or sw sequence restores defaults
// [RULE10] one data bit per clock pulse; data changes only while clock low
// [RULE11] idle bus has both lines high; start only when not busy
// [RULE12] data falling while clock high is start
// [RULE13] data rising while clock high is stop
// [RULE14] each byte is eight bits plus one acknowledge bit, unlimited count
// [RULE15] receivers acknowledge by holding data low during ack clock high
// [RULE16] master receiver withholds last ack; slave then leaves data high
// [RULE17] after bus error keep status and stay off bus until reset
`include "ibei_consts.vh"
module ibei_top #(
  parameter INIT_CYCLES = `IBEI_INIT_CYCLES,
  parameter RST_CYCLES = `IBEI_RST_CYCLES
) (
  input wire sys_clk,
  input wire rst_b,
  input wire clk_en,
  input wire reset_pin_b,
  input wire sw_reset_wr,
  input wire [7:0] sw_reset_data,
  input wire host_wr,
  input wire role_master,
  input wire role_slave_addr,
  input wire rx_ack_en,
  input wire scl_in,
  input wire sda_in,
  output wire scl_out,
  output wire scl_oe_b,
  output wire sda_out,
  output wire sda_oe_b,
  output reg [7:0] control_register,
  output reg [7:0] status_r,
  output reg bus_error_r,
  output reg init_busy_r,
  output reg wr_refused_r,
  output wire bus_idle
);
  localparam ST_INIT = 2'd0;
  localparam ST_READY = 2'd1;
  localparam ST_ERROR = 2'd2;

  wire [1:0] sync_w;
  wire scl_s;
  wire sda_s;
  wire rstpin_s;
  wire start_p;
  wire stop_p;
  wire scl_rise_p;
  reg [1:0] state_r;
  reg [31:0] init_cnt_r;
  reg [31:0] rpw_cnt_r;
  reg [3:0] bit_cnt_r;
  reg in_frame_r;
  reg sw_arm_r;
  reg ack_drive_r;
  reg rstpin_m_r;
  reg rstpin_r;
  reg scl_q_r;
  wire scl_fall_p;
  wire involved;
  wire pin_reset;
  wire sw_reset;
  wire soft_reset;

  // sync bus lines
  ibei_sync #(.W(2)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in({scl_in, sda_in}),
    .sync_out(sync_w)
  );
  assign scl_s = sync_w[1];
  assign sda_s = sync_w[0];

  // reset pin is a pin: two flops
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      rstpin_m_r <= 1'b1;
      rstpin_r <= 1'b1;
    end else begin
      rstpin_m_r <= reset_pin_b;
      rstpin_r <= rstpin_m_r;
    end
  end
  assign rstpin_s = rstpin_r;

  // scl falling edge, so the ack bit only moves while the clock is low
  always @(posedge sys_clk) begin
    if (!rst_b)
      scl_q_r <= 1'b1;
    else if (clk_en)
      scl_q_r <= scl_s;
  end
  assign scl_fall_p = clk_en & scl_q_r & ~scl_s; // [RULE10]

  ibei_cond u_cond (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .start_p(start_p),
    .stop_p(stop_p),
    .scl_rise_p(scl_rise_p),
    .bus_idle(bus_idle)
  );

  // reset pin low-width counter
  always @(posedge sys_clk) begin
    if (!rst_b)
      rpw_cnt_r <= 32'd0;
    else if (clk_en) begin
      if (rstpin_s)
        rpw_cnt_r <= 32'd0;
      else if (rpw_cnt_r < RST_CYCLES)
        rpw_cnt_r <= rpw_cnt_r + 32'd1;
    end
  end
  assign pin_reset = clk_en & ~rstpin_s & (rpw_cnt_r >= RST_CYCLES - 1); // [RULE9]

  // two-write software reset key
  always @(posedge sys_clk) begin
    if (!rst_b)
      sw_arm_r <= 1'b0;
    else if (clk_en && sw_reset_wr)
      sw_arm_r <= (sw_reset_data == `IBEI_SW_KEY0);
  end
  assign sw_reset = clk_en & sw_reset_wr & sw_arm_r & (sw_reset_data == `IBEI_SW_KEY1); // [RULE9]
  assign soft_reset = pin_reset | sw_reset;

  assign involved = role_master | role_slave_addr; // [RULE2]

  // frame bit counter: 8 data bits then ack
  always @(posedge sys_clk) begin
    if (!rst_b || soft_reset) begin
      bit_cnt_r <= 4'd0;
      in_frame_r <= 1'b0;
    end else if (clk_en) begin
      if (start_p) begin
        bit_cnt_r <= 4'd0;
        in_frame_r <= 1'b1;
      end else if (stop_p) begin
        in_frame_r <= 1'b0;
        bit_cnt_r <= 4'd0;
      end else if (scl_rise_p && in_frame_r) begin
        if (bit_cnt_r == 4'd8)
          bit_cnt_r <= 4'd0; // [RULE14]
        else
          bit_cnt_r <= bit_cnt_r + 4'd1;
      end
    end
  end

  // ack drive: low after 8th bit, off when nack requested
  always @(posedge sys_clk) begin
    if (!rst_b || soft_reset)
      ack_drive_r <= 1'b0;
    else if (clk_en) begin
      if (state_r != ST_READY || !involved)
        ack_drive_r <= 1'b0; // [RULE17]
      else if (scl_fall_p && bit_cnt_r == 4'd8)
        ack_drive_r <= rx_ack_en; // [RULE15] [RULE16]
      else if (scl_fall_p && bit_cnt_r == 4'd0)
        ack_drive_r <= 1'b0; // [RULE14]
    end
  end

  // main sequencer: init, ready, error
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state_r <= ST_INIT;
      init_cnt_r <= 32'd0;
      init_busy_r <= 1'b1;
      control_register <= `IBEI_CON_RESET;
      status_r <= `IBEI_STA_IDLE;
      bus_error_r <= 1'b0;
    end else if (clk_en) begin
      if (soft_reset) begin
        state_r <= ST_READY;
        control_register <= `IBEI_CON_RESET;
        status_r <= `IBEI_STA_IDLE;
        bus_error_r <= 1'b0;
      end else begin
        case (state_r)
          ST_INIT: begin
            control_register[`IBEI_CON_OSC_BIT] <= 1'b1; // [RULE5] [RULE8]
            if (init_cnt_r >= INIT_CYCLES - 1) begin
              control_register <= `IBEI_CON_RESET; // [RULE5] [RULE8]
              status_r <= `IBEI_STA_IDLE;
              init_busy_r <= 1'b0;
              state_r <= ST_READY; // [RULE6]
            end else
              init_cnt_r <= init_cnt_r + 32'd1;
          end
          ST_READY: begin
            // count 1 is the first clock of a fresh byte (legal stop or restart); count 0, after a start or during the ack clock, is not checked either
            if ((start_p || stop_p) && in_frame_r && involved && bit_cnt_r > 4'd1) begin
              status_r <= `IBEI_STA_BUS_ERR; // [RULE1] [RULE3]
              control_register[`IBEI_CON_SI_BIT] <= 1'b1; // [RULE3]
              bus_error_r <= 1'b1;
              state_r <= ST_ERROR;
            end
          end
          ST_ERROR: begin
            status_r <= `IBEI_STA_BUS_ERR; // [RULE17] [RULE4]
          end
          default: state_r <= ST_INIT;
        endcase
      end
    end
  end

  // flag host writes during init; reads need nothing
  always @(posedge sys_clk) begin
    if (!rst_b)
      wr_refused_r <= 1'b0;
    else if (clk_en)
      wr_refused_r <= host_wr & init_busy_r; // [RULE7]
  end

  // open drain: oe_b low means driving low
  assign scl_out = 1'b0;
  assign scl_oe_b = 1'b1; // [RULE3]
  assign sda_out = 1'b0;
  assign sda_oe_b = ~ack_drive_r; // [RULE3] [RULE10]
endmodule

// file: verification/ibei_chk_assertions.sv
// Purpose: port checks on ibei_top
// Assumes: clk_en high
// Notes: bind below
module ibei_chk #(parameter INIT_CYCLES = 20) (
  input wire sys_clk, rst_b, sw_reset_wr, reset_pin_b,
  input wire role_master, role_slave_addr, scl_oe_b, sda_oe_b,
  input wire [7:0] control_register, status_r,
  input wire bus_error_r, init_busy_r
);
  int busy_cnt = 0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // length of init phase
  always @(posedge sys_clk) busy_cnt <= init_busy_r ? busy_cnt + 1 : 0;
  a_scl_released: assert property (scl_oe_b) else $error("scl driven");
  a_err_status: assert property (bus_error_r |-> status_r == 8'h00 && control_register[3])
    else $error("bad error status");
  a_err_release: assert property (bus_error_r |-> sda_oe_b) else $error("sda held");
  a_err_sticky: assert property (bus_error_r && reset_pin_b && $past(reset_pin_b) &&
    $past(reset_pin_b, 2) && $past(reset_pin_b, 3) && $past(reset_pin_b, 4) &&
    !sw_reset_wr && !$past(sw_reset_wr) |=> bus_error_r) else $error("error lost");
  a_err_involved: assert property ($rose(bus_error_r) |->
    $past(role_master || role_slave_addr)) else $error("error while idle");
  a_osc_busy: assert property (init_busy_r && $past(rst_b) |-> control_register[5])
    else $error("osc bit low in init");
  a_osc_ready: assert property ($fell(init_busy_r) |-> control_register == 8'h00)
    else $error("control not cleared");
  a_init_time: assert property (busy_cnt <= INIT_CYCLES + 8) else $error("init too long");
  a_ack_release: assert property (!sda_oe_b |-> ##[1:40] sda_oe_b) else $error("ack stuck");
  cover property ($rose(bus_error_r));
  cover property ($fell(sda_oe_b));
  cover property ($fell(init_busy_r));
endmodule
bind ibei_top ibei_chk #(.INIT_CYCLES(INIT_CYCLES)) chk_u (.*);

// file: verification/ibei_bus_model.sv
// Purpose: far-side bus master on open-drain lines
// Assumes: pull-ups on both lines
// Notes: 64 ns bit clock
module ibei_bus_model (output logic scl_m, output logic sda_m);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // data falls while clock high
  task automatic start_c();
    sda_m = 1'b1; scl_m = 1'b1; #32 sda_m = 1'b0; #32 scl_m = 1'b0;
  endtask
  // data rises while clock high, bus left idle
  task automatic stop_c();
    sda_m = 1'b0; #32 scl_m = 1'b1; #32 sda_m = 1'b1;
  endtask
  // data set only while clock low
  task automatic put(input logic b);
    sda_m = b; #32 scl_m = 1'b1; #8;
  endtask
  task automatic fall(); #24 scl_m = 1'b0; endtask
endmodule

// file: verification/tb.sv
// Purpose: self-checking bench for ibei_top
// Assumes: short init count
// Notes: notes queued, watcher compares
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst_b = 0, reset_pin_b = 1, sw_reset_wr = 0, host_wr = 0;
  logic role_master = 0, role_slave_addr = 0, rx_ack_en = 0;
  logic [7:0] sw_reset_data = 8'h00, cur_exp;
  logic [3:0] cur_id;
  wire scl_m, sda_m, scl_out, scl_oe_b, sda_out, sda_oe_b, err, busy, refused, idle;
  wire [7:0] ctrl, status;
  wire scl_in = scl_m & (scl_oe_b | scl_out);
  wire sda_in = sda_m & (sda_oe_b | sda_out);
  int error_cnt = 0, compares = 0;
  logic [3:0] id_q[$];
  logic [7:0] exp_q[$];
  always #2 sys_clk = ~sys_clk;
  ibei_top #(.INIT_CYCLES(20)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1),
    .reset_pin_b(reset_pin_b), .sw_reset_wr(sw_reset_wr), .sw_reset_data(sw_reset_data),
    .host_wr(host_wr), .role_master(role_master), .role_slave_addr(role_slave_addr),
    .rx_ack_en(rx_ack_en), .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out),
    .scl_oe_b(scl_oe_b), .sda_out(sda_out), .sda_oe_b(sda_oe_b), .control_register(ctrl),
    .status_r(status), .bus_error_r(err), .init_busy_r(busy), .wr_refused_r(refused),
    .bus_idle(idle));
  ibei_bus_model bus_u (.scl_m(scl_m), .sda_m(sda_m));
  // watcher: oldest note against the outputs
  always @(posedge sys_clk) begin
    #1;
    if (id_q.size() > 0) begin
      cur_id = id_q.pop_front();
      cur_exp = exp_q.pop_front();
      case (cur_id)
        0: `CHK("status", cur_exp, status)
        1: `CHK("bus error", cur_exp, {7'h00, err})
        2: `CHK("osc bit", cur_exp, {7'h00, ctrl[5]})
        3: `CHK("sda line", cur_exp, {7'h00, sda_in})
        5: `CHK("write refused", cur_exp, {7'h00, refused})
        6: `CHK("bus idle", cur_exp, {7'h00, idle})
        default: `CHK("int flag", cur_exp, {7'h00, ctrl[3]})
      endcase
    end
  end
  task automatic note(input logic [3:0] id, input logic [7:0] e);
    id_q.push_back(id);
    exp_q.push_back(e);
  endtask
  task automatic cyc(input int n); repeat (n) @(negedge sys_clk); endtask
  task automatic print_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // bounded wait: init done (0) or bus error (1)
  task automatic wait_lvl(input bit w);
    int k;
    k = 0;
    while ((w ? err !== 1'b1 : busy !== 1'b0) && k < 60) begin cyc(1); k++; end
    if (k == 60) begin error_cnt++; print_verdict(); end
  endtask
  // eight random bits then the ack bit
  task automatic byte_io(input logic ack_line);
    logic [7:0] d;
    d = 8'($urandom);
    for (int i = 7; i >= 0; i--) begin bus_u.put(d[i]); bus_u.fall(); end
    bus_u.put(1'b1);
    note(3, {7'h00, ack_line});
    bus_u.fall();
  endtask
  initial begin
    void'($urandom(65331));
    cyc(3);
    rst_b = 1;
    cyc(2);
    note(5, 8'h01);
    note(2, 8'h01);
    host_wr = 1;
    cyc(1);
    host_wr = 0;
    wait_lvl(0);
    cyc(2);
    note(2, 8'h00);
    note(0, 8'hf8);
    note(6, 8'h01);
    bus_u.start_c();
    bus_u.put(1'b0);
    bus_u.stop_c();
    cyc(10);
    note(1, 8'h00);
    role_slave_addr = 1;
    rx_ack_en = 1;
    bus_u.start_c();
    byte_io(1'b0);
    rx_ack_en = 0;
    byte_io(1'b1);
    bus_u.stop_c();
    cyc(10);
    note(1, 8'h00);
    for (int r = 0; r < 2; r++) begin
      role_master = 1'(r);
      role_slave_addr = 1'(1 - r);
      bus_u.start_c();
      bus_u.put(1'b1);
      bus_u.fall();
      bus_u.stop_c();
      wait_lvl(1);
      note(0, 8'h00);
      note(4, 8'h01);
      bus_u.start_c();
      bus_u.stop_c();
      cyc(8);
      note(0, 8'h00);
      cyc(8);
      if (r == 0) begin
        sw_reset_data = 8'ha5;
        sw_reset_wr = 1;
        cyc(1);
        sw_reset_data = 8'h5a;
        cyc(1);
        sw_reset_wr = 0;
      end else begin
        reset_pin_b = 0;
        cyc(6);
        reset_pin_b = 1;
      end
      cyc(8);
      note(1, 8'h00);
      note(0, 8'hf8);
      note(4, 8'h00);
      cyc(8);
    end
    print_verdict();
  end
endmodule
